// ==== hw/ieee488_talk_listen.sv ====
`timescale 1ns/1ns
module ieee488_talk_listen #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Non-volatile settings, applied after reset release
    input wire logic nv_valid,
    input wire logic [4:0] nv_addr,
    input wire logic [7:0] nv_ese,
    input wire logic [7:0] nv_sre,
    input wire logic power_up_status_clear_choice,
    input wire logic factory_config,
    // Bus control lines, active low as on the cable
    input wire logic atn_n,
    input wire logic ifc_n,
    input wire logic ren_n,
    input wire logic eoi_n_in,
    output logic eoi_n_out,
    output logic eoi_n_oe,
    // Data lines, active low
    input wire logic [7:0] dio_n_in,
    output logic [7:0] dio_n_out,
    output logic dio_n_oe,
    // Handshake lines
    input wire logic dav_n_in,
    output logic dav_n_out,
    output logic dav_n_oe,
    input wire logic nrfd_n_in,
    output logic nrfd_n_out,
    output logic nrfd_n_oe,
    input wire logic ndac_n_in,
    output logic ndac_n_out,
    output logic ndac_n_oe,
    output logic srq_n_out,
    output logic srq_n_oe,
    // Received data to the parser
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end,
    input wire logic rx_ready,
    // Output queue from the response formatter
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    // Status and service request
    input wire logic [7:0] status_byte,
    input wire logic service_req,
    // Front panel
    input wire logic panel_key,
    input wire logic panel_entry_busy,
    input wire logic panel_local_key,
    output logic panel_key_ok,
    output logic panel_abort,
    // State reported to firmware
    output logic remote_ff,
    output logic lockout_ff,
    output logic talker_ff,
    output logic listener_ff,
    output logic dev_clear,
    output logic pon_event,
    output logic [4:0] bus_addr,
    output logic [7:0] ese_ff,
    output logic [7:0] sre_ff
);
    // =====================================================================
    // Declarations
    logic [4:0] addr_ff, nxt_addr;
    logic [7:0] nxt_ese, nxt_sre;
    logic cfg_done_ff, nxt_cfg_done, pon_ff, nxt_pon;
    logic nxt_remote, nxt_lockout, nxt_talker, nxt_listener;
    logic spoll_ff, nxt_spoll, clr_ff, nxt_clr, abort_ff, nxt_abort;
    logic srq_ff, nxt_srq, keyok_ff, nxt_keyok;
    logic acc_ff, nxt_acc;
    ieee488_pkg::src_state_t src_ff, nxt_src;
    logic [7:0] sdata_ff, nxt_sdata;
    logic seoi_ff, nxt_seoi;
    logic rxv_ff, nxt_rxv, rxe_ff, nxt_rxe;
    logic [7:0] rxd_ff, nxt_rxd;
    logic acc_on, byte_in, cmd_in, data_in;
    logic [7:0] bus_byte;
    logic q_valid, q_ready, q_last;
    logic [7:0] q_data;
    logic [8:0] q_word;

    // Output queue buffered between formatter and source handshake
    byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_outq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .flush(clr_ff),
        .in_valid(tx_valid),
        .in_data({tx_last, tx_data}),
        .in_ready(tx_ready),
        .out_valid(q_valid),
        .out_data(q_word),
        .out_ready(q_ready)
    );
    assign q_data = q_word[7:0];
    assign q_last = q_word[8];

    // =====================================================================
    // Acceptor: a byte is latched when DAV falls while we hold NRFD off
    always_comb begin
        bus_byte = ~dio_n_in;
        // Accept commands always, data only while listening; otherwise
        // leave NRFD and NDAC alone so our own talker can finish
        acc_on = !atn_n || listener_ff;
        byte_in = !dav_n_in && !acc_ff && acc_on;
        cmd_in = byte_in && !atn_n;
        data_in = byte_in && atn_n && !rxv_ff;
        nxt_acc = acc_ff;
        if (!acc_ff && (cmd_in || data_in)) begin
            nxt_acc = 1'b1;
        end else if (acc_ff && dav_n_in) begin
            nxt_acc = 1'b0;
        end
        nxt_rxv = rxv_ff && !rx_ready;
        nxt_rxd = rxd_ff;
        nxt_rxe = rxe_ff;
        if (data_in) begin
            nxt_rxv = 1'b1;
            nxt_rxd = bus_byte;
            nxt_rxe = !eoi_n_in;
        end
        if (clr_ff) begin
            nxt_rxv = 1'b0;
        end
    end

    // =====================================================================
    // Settings, addressing, remote/local and clear
    always_comb begin
        nxt_cfg_done = cfg_done_ff || nv_valid;
        nxt_addr = addr_ff;
        nxt_ese = ese_ff;
        nxt_sre = sre_ff;
        nxt_pon = 1'b0;
        if (nv_valid && !cfg_done_ff) begin
            // Out-of-range stored value falls back to factory address
            nxt_addr = (factory_config || nv_addr > ieee488_pkg::ADDR_MAX) ?
                ieee488_pkg::ADDR_FACTORY : nv_addr;
            nxt_ese = nv_ese;
            nxt_sre = nv_sre;
            nxt_pon = power_up_status_clear_choice;
        end
        nxt_remote = remote_ff;
        nxt_lockout = lockout_ff;
        nxt_talker = talker_ff;
        nxt_listener = listener_ff;
        nxt_spoll = spoll_ff;
        nxt_clr = 1'b0;
        nxt_abort = 1'b0;
        if (cmd_in) begin
            unique case (bus_byte[6:5])
                ieee488_pkg::GRP_LAG: begin
                    if (bus_byte[4:0] == ieee488_pkg::ADDR_UNL) begin
                        nxt_listener = 1'b0;
                    end else if (bus_byte[4:0] == addr_ff) begin
                        nxt_listener = 1'b1;
                        nxt_talker = 1'b0;
                        nxt_remote = !ren_n;
                    end
                end
                ieee488_pkg::GRP_TAG: begin
                    if (bus_byte[4:0] == addr_ff) begin
                        nxt_talker = 1'b1;
                        nxt_listener = 1'b0;
                    end else begin
                        nxt_talker = 1'b0;
                    end
                end
                // Secondary codes carry no meaning here
                ieee488_pkg::GRP_SCG: ;
                ieee488_pkg::GRP_ACG_UCG: begin
                    if (bus_byte[6:0] == ieee488_pkg::CMD_DCL ||
                        (bus_byte[6:0] == ieee488_pkg::CMD_SDC &&
                         listener_ff)) begin
                        nxt_clr = 1'b1;
                    end
                    // Lockout is a bus message too, so it also goes remote
                    if (bus_byte[6:0] == ieee488_pkg::CMD_LLO) begin
                        nxt_lockout = 1'b1;
                        nxt_remote = !ren_n;
                    end
                    if (bus_byte[6:0] == ieee488_pkg::CMD_GTL &&
                        listener_ff) begin
                        nxt_remote = 1'b0;
                    end
                    if (bus_byte[6:0] == ieee488_pkg::CMD_SPE) begin
                        nxt_spoll = 1'b1;
                    end
                    if (bus_byte[6:0] == ieee488_pkg::CMD_SPD) begin
                        nxt_spoll = 1'b0;
                    end
                    // GET and all other codes here pass untouched
                end
            endcase
        end
        // Data to us is a bus message: go remote, drop panel entry
        if (data_in) begin
            nxt_remote = !ren_n;
            nxt_abort = panel_entry_busy;
        end
        if (cmd_in && bus_byte[6:5] == ieee488_pkg::GRP_LAG &&
            bus_byte[4:0] == addr_ff) begin
            nxt_abort = panel_entry_busy;
        end
        if (remote_ff && !lockout_ff && panel_local_key) begin
            nxt_remote = 1'b0;
        end
        if (ren_n) begin
            nxt_remote = 1'b0;
            nxt_lockout = 1'b0;
        end
        if (!ifc_n) begin
            nxt_talker = 1'b0;
            nxt_listener = 1'b0;
            nxt_spoll = 1'b0;
        end
        // Panel keys pass only in local state
        nxt_keyok = panel_key && !nxt_remote;
    end

    // =====================================================================
    // Source handshake for response bytes and poll status
    always_comb begin
        nxt_src = src_ff;
        nxt_sdata = sdata_ff;
        nxt_seoi = seoi_ff;
        q_ready = 1'b0;
        unique case (src_ff)
            ieee488_pkg::SRC_IDLE: begin
                if (talker_ff && atn_n && spoll_ff) begin
                    nxt_sdata = {status_byte[7], srq_ff, status_byte[5:0]};
                    nxt_seoi = 1'b0;
                    nxt_src = ieee488_pkg::SRC_WAIT_RFD;
                end else if (talker_ff && atn_n && q_valid) begin
                    q_ready = 1'b1;
                    nxt_sdata = q_data;
                    nxt_seoi = q_last;
                    nxt_src = ieee488_pkg::SRC_WAIT_RFD;
                end
            end
            ieee488_pkg::SRC_WAIT_RFD: begin
                if (nrfd_n_in) begin
                    nxt_src = ieee488_pkg::SRC_DAV;
                end
            end
            ieee488_pkg::SRC_DAV: begin
                if (ndac_n_in) begin
                    nxt_src = ieee488_pkg::SRC_RELEASE;
                end
            end
            ieee488_pkg::SRC_RELEASE: begin
                nxt_src = ieee488_pkg::SRC_IDLE;
            end
        endcase
        if (!atn_n || !talker_ff || clr_ff) begin
            nxt_src = ieee488_pkg::SRC_IDLE;
        end
        // Poll answer drops the request for one cycle once taken; service_req raises it again
        nxt_srq = service_req &&
                  !(src_ff == ieee488_pkg::SRC_RELEASE && spoll_ff);
    end

    // =====================================================================
    // Registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_done_ff <= 1'b0;
            addr_ff <= ieee488_pkg::ADDR_FACTORY;
            ese_ff <= 8'h00;
            sre_ff <= 8'h00;
            pon_ff <= 1'b0;
            remote_ff <= 1'b0;
            lockout_ff <= 1'b0;
            talker_ff <= 1'b0;
            listener_ff <= 1'b0;
            spoll_ff <= 1'b0;
            clr_ff <= 1'b0;
            abort_ff <= 1'b0;
            keyok_ff <= 1'b0;
            srq_ff <= 1'b0;
            acc_ff <= 1'b0;
            src_ff <= ieee488_pkg::SRC_IDLE;
            sdata_ff <= 8'h00;
            seoi_ff <= 1'b0;
            rxv_ff <= 1'b0;
            rxd_ff <= 8'h00;
            rxe_ff <= 1'b0;
        end else begin
            cfg_done_ff <= nxt_cfg_done;
            addr_ff <= nxt_addr;
            ese_ff <= nxt_ese;
            sre_ff <= nxt_sre;
            pon_ff <= nxt_pon;
            remote_ff <= nxt_remote;
            lockout_ff <= nxt_lockout;
            talker_ff <= nxt_talker;
            listener_ff <= nxt_listener;
            spoll_ff <= nxt_spoll;
            clr_ff <= nxt_clr;
            abort_ff <= nxt_abort;
            keyok_ff <= nxt_keyok;
            srq_ff <= nxt_srq;
            acc_ff <= nxt_acc;
            src_ff <= nxt_src;
            sdata_ff <= nxt_sdata;
            seoi_ff <= nxt_seoi;
            rxv_ff <= nxt_rxv;
            rxd_ff <= nxt_rxd;
            rxe_ff <= nxt_rxe;
        end
    end

    // =====================================================================
    // Pin drive; ATN, IFC and REN have no driver at all
    assign dio_n_out = ~sdata_ff;
    assign dio_n_oe = src_ff != ieee488_pkg::SRC_IDLE;
    assign eoi_n_out = ~seoi_ff;
    assign eoi_n_oe = src_ff != ieee488_pkg::SRC_IDLE && seoi_ff;
    assign dav_n_out = 1'b0;
    assign dav_n_oe = src_ff == ieee488_pkg::SRC_DAV;
    assign nrfd_n_out = 1'b0;
    // Hold off until parser drains; commands under ATN never wait
    assign nrfd_n_oe = acc_on && (acc_ff || (rxv_ff && atn_n));
    assign ndac_n_out = 1'b0;
    assign ndac_n_oe = acc_on && !acc_ff;
    assign srq_n_out = 1'b0;
    assign srq_n_oe = srq_ff;
    assign rx_valid = rxv_ff;
    assign rx_data = rxd_ff;
    assign rx_end = rxe_ff;
    assign panel_key_ok = keyok_ff;
    assign panel_abort = abort_ff;
    assign dev_clear = clr_ff;
    assign pon_event = pon_ff;
    assign bus_addr = addr_ff;

    // =====================================================================
    // Checks
    AST_TALK_DROPS_LISTEN: assert property (@(posedge core_clk)
        disable iff (!rst_n) $rose(talker_ff) |-> !listener_ff)
        else $error("listener kept while talker");
    AST_LISTEN_DROPS_TALK: assert property (@(posedge core_clk)
        disable iff (!rst_n) $rose(listener_ff) |-> !talker_ff)
        else $error("talker kept while listener");
    AST_REMOTE_PANEL: assert property (@(posedge core_clk)
        disable iff (!rst_n) remote_ff |-> !panel_key_ok)
        else $error("panel key passed in remote");
    AST_DCL: assert property (@(posedge core_clk)
        disable iff (!rst_n) (cmd_in && bus_byte[6:0] == ieee488_pkg::CMD_DCL)
        |=> dev_clear)
        else $error("DCL did not clear");
    AST_LOCKOUT: assert property (@(posedge core_clk)
        disable iff (!rst_n) (lockout_ff && remote_ff && !ren_n && !cmd_in)
        |=> remote_ff)
        else $error("local key worked under lockout");
    AST_ADDR_RANGE: assert property (@(posedge core_clk)
        disable iff (!rst_n) bus_addr <= ieee488_pkg::ADDR_MAX)
        else $error("address out of range");
    AST_DAV_AFTER_RFD: assert property (@(posedge core_clk)
        disable iff (!rst_n) $rose(dav_n_oe) |-> $past(nrfd_n_in))
        else $error("DAV asserted without ready");
    AST_ABORT: assert property (@(posedge core_clk)
        disable iff (!rst_n) (data_in && panel_entry_busy) |=> panel_abort)
        else $error("panel entry not aborted");
endmodule

// ==== hw/ieee488_pkg.sv ====
package ieee488_pkg;
    // =====================================================================
    // Addressing
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [4:0] ADDR_FACTORY = 5'h12;
    localparam logic [4:0] ADDR_UNL = 5'h1f;
    // =====================================================================
    // Command groups on DIO with ATN asserted (7-bit codes)
    localparam logic [1:0] GRP_ACG_UCG = 2'h0;
    localparam logic [1:0] GRP_LAG = 2'h1;
    localparam logic [1:0] GRP_TAG = 2'h2;
    localparam logic [1:0] GRP_SCG = 2'h3;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    // =====================================================================
    // Status byte bit positions
    localparam int STB_RQS = 6;
    localparam int STB_MAV = 4;
    // =====================================================================
    // Source handshake states
    typedef enum logic [1:0] {
        SRC_IDLE = 2'b00,
        SRC_WAIT_RFD = 2'b01,
        SRC_DAV = 2'b10,
        SRC_RELEASE = 2'b11
    } src_state_t;
endpackage

// ==== hw/byte_fifo.sv ====
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic do_wr, do_rd;

    // =====================================================================
    // Pointers carry one extra bit to tell full from empty
    always_comb begin
        in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
        out_valid = wr_ff != rd_ff;
        out_data = mem[rd_ff[AW-1:0]];
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        nxt_wr = flush ? '0 : wr_ff + (AW+1)'(do_wr);
        nxt_rd = flush ? '0 : rd_ff + (AW+1)'(do_rd);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    // Storage has no reset; only the pointers matter
    always_ff @(posedge core_clk) begin
        if (do_wr && !flush) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==== tb/bus_ctrl_model.sv ====
`timescale 1ns/1ns
// ==================================================================
// Bus controller standing on the far side of the cable
module bus_ctrl_model (
    // Clock
    input wire logic core_clk,
    // Resolved bus lines, active low
    input wire logic [7:0] dio_n,
    input wire logic dav_n,
    input wire logic nrfd_n,
    input wire logic ndac_n,
    input wire logic eoi_n,
    // Controller drive, 1 means released
    output logic atn_n,
    output logic [7:0] c_dio_n,
    output logic c_dav_n,
    output logic c_nrfd_n,
    output logic c_ndac_n,
    output logic c_eoi_n
);
    // Idle: not ready and nothing accepted
    initial begin
        atn_n = 1'b1;
        c_dio_n = 8'hff;
        c_dav_n = 1'b1;
        c_nrfd_n = 1'b0;
        c_ndac_n = 1'b0;
        c_eoi_n = 1'b1;
    end
    // Source side; waits are bounded so a silent device cannot hang us
    task automatic put_byte(input logic atn, input logic [7:0] b,
                            input logic eoi, output logic ok);
        int n;
        @(negedge core_clk);
        atn_n = ~atn;
        c_dio_n = ~b;
        c_eoi_n = ~eoi;
        c_nrfd_n = 1'b1;
        c_ndac_n = 1'b1;
        ok = 1'b0;
        for (n = 0; n < 200 && !ok; n++) begin
            @(negedge core_clk);
            ok = (nrfd_n === 1'b1);
        end
        if (ok) begin
            c_dav_n = 1'b0;
            ok = 1'b0;
            for (n = 0; n < 50 && !ok; n++) begin
                @(negedge core_clk);
                ok = (ndac_n === 1'b1);
            end
        end
        // Released lines float up to the pull-up level
        c_dav_n = 1'b1;
        c_dio_n = 8'hff;
        c_eoi_n = 1'b1;
    endtask
    // Acceptor side; slow adds cycles before ready is shown
    task automatic get_byte(input int slow, output logic [8:0] b,
                            output logic ok);
        int n;
        @(negedge core_clk);
        atn_n = 1'b1;
        // Hold NDAC low until a byte arrives, and NRFD low until we are ready for it
        c_ndac_n = 1'b0;
        c_nrfd_n = (slow == 0);
        if (slow > 0) begin
            repeat (slow) @(negedge core_clk);
            c_nrfd_n = 1'b1;
        end
        ok = 1'b0;
        b = 9'h000;
        for (n = 0; n < 200 && !ok; n++) begin
            @(negedge core_clk);
            ok = (dav_n === 1'b0);
        end
        if (ok) begin
            b = {~eoi_n, ~dio_n};
            c_nrfd_n = 1'b0;
            c_ndac_n = 1'b1;
            for (n = 0; n < 50 && dav_n !== 1'b1; n++) @(negedge core_clk);
            c_ndac_n = 1'b0;
        end
    endtask
endmodule

// ==== tb/gpib_talker_listener_interface_test.sv ====
`timescale 1ns/1ns
module gpib_talker_listener_interface_test;
    localparam int DEPTH = 16;
    logic core_clk, rst_n, nv_valid, factory_config;
    logic power_up_status_clear_choice, ren_n, atn_n, ok;
    logic [4:0] nv_addr, bus_addr, addr, other;
    logic [7:0] nv_ese, nv_sre, ese_ff, sre_ff, status_byte;
    logic [7:0] tx_data, rx_data, dio_n_out, c_dio_n;
    logic service_req, panel_key, panel_entry_busy, panel_local_key;
    logic panel_key_ok, panel_abort, rx_ready, rx_valid, rx_end;
    logic tx_valid, tx_last, tx_ready, remote_ff, lockout_ff, talker_ff;
    logic listener_ff, dev_clear, pon_event, srq_n_out, srq_n_oe;
    logic eoi_n_out, eoi_n_oe, dio_n_oe, dav_n_out, dav_n_oe, nrfd_n_out;
    logic nrfd_n_oe, ndac_n_out, ndac_n_oe, c_dav_n, c_nrfd_n, c_ndac_n;
    logic c_eoi_n;
    logic [8:0] got;
    logic [8:0] rx_exp[$], rx_got[$], tx_exp[$];
    int error_cnt, samples_checked, clr_cnt, pon_cnt, abort_cnt, i;
    int seed = 32'h5663;
    // ==================================================================
    // Open-collector wires: low if any party pulls low
    wire [7:0] dio_w = (dio_n_oe ? dio_n_out : 8'hff) & c_dio_n;
    wire dav_w = (dav_n_oe ? dav_n_out : 1'b1) & c_dav_n;
    wire nrfd_w = (nrfd_n_oe ? nrfd_n_out : 1'b1) & c_nrfd_n;
    wire ndac_w = (ndac_n_oe ? ndac_n_out : 1'b1) & c_ndac_n;
    wire eoi_w = (eoi_n_oe ? eoi_n_out : 1'b1) & c_eoi_n;
    ieee488_talk_listen #(.FIFO_DEPTH(DEPTH)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .nv_valid(nv_valid),
        .nv_addr(nv_addr), .nv_ese(nv_ese), .nv_sre(nv_sre),
        .power_up_status_clear_choice(power_up_status_clear_choice),
        .factory_config(factory_config), .atn_n(atn_n), .ifc_n(1'b1),
        .ren_n(ren_n), .eoi_n_in(eoi_w), .eoi_n_out(eoi_n_out),
        .eoi_n_oe(eoi_n_oe), .dio_n_in(dio_w), .dio_n_out(dio_n_out),
        .dio_n_oe(dio_n_oe), .dav_n_in(dav_w), .dav_n_out(dav_n_out),
        .dav_n_oe(dav_n_oe), .nrfd_n_in(nrfd_w), .nrfd_n_out(nrfd_n_out),
        .nrfd_n_oe(nrfd_n_oe), .ndac_n_in(ndac_w), .ndac_n_out(ndac_n_out),
        .ndac_n_oe(ndac_n_oe), .srq_n_out(srq_n_out), .srq_n_oe(srq_n_oe),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .status_byte(status_byte),
        .service_req(service_req), .panel_key(panel_key),
        .panel_entry_busy(panel_entry_busy),
        .panel_local_key(panel_local_key), .panel_key_ok(panel_key_ok),
        .panel_abort(panel_abort), .remote_ff(remote_ff),
        .lockout_ff(lockout_ff), .talker_ff(talker_ff),
        .listener_ff(listener_ff), .dev_clear(dev_clear),
        .pon_event(pon_event), .bus_addr(bus_addr), .ese_ff(ese_ff),
        .sre_ff(sre_ff));
    bus_ctrl_model ctrl (
        .core_clk(core_clk), .dio_n(dio_w), .dav_n(dav_w), .nrfd_n(nrfd_w),
        .ndac_n(ndac_w), .eoi_n(eoi_w), .atn_n(atn_n), .c_dio_n(c_dio_n),
        .c_dav_n(c_dav_n), .c_nrfd_n(c_nrfd_n), .c_ndac_n(c_ndac_n),
        .c_eoi_n(c_eoi_n));
    // ==================================================================
    // Clock, pulse counters, receive collector and stalling parser
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (dev_clear === 1'b1) clr_cnt++;
        if (pon_event === 1'b1) pon_cnt++;
        if (panel_abort === 1'b1) abort_cnt++;
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            rx_got.push_back({rx_end, rx_data});
    end
    always @(negedge core_clk) rx_ready <= ($random(seed) % 4) != 0;
    // Watchdog sized well above the expected run of a few hundred cycles
    initial begin
        #300000;
        error_cnt++;
        complete_run();
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checked=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        logic acc;
        ctrl.put_byte(1'b1, b, 1'b0, acc);
        check(acc, 1);
        @(negedge core_clk); // Let one-cycle pulses be counted
    endtask
    task automatic send_data(input int cnt, input logic take);
        logic [7:0] b;
        logic acc;
        for (int k = 0; k < cnt; k++) begin
            b = $random(seed);
            ctrl.put_byte(1'b0, b, k == cnt - 1, acc);
            check({acc, listener_ff}, {1'b1, take});
            if (take) rx_exp.push_back({k == cnt - 1, b});
        end
        repeat (12) @(negedge core_clk);
        check(rx_got.size(), rx_exp.size());
        while (rx_got.size() > 0 && rx_exp.size() > 0)
            check(rx_got.pop_front(), rx_exp.pop_front());
        rx_got.delete();
        rx_exp.delete();
    endtask
    task automatic press_local();
        @(negedge core_clk);
        panel_local_key = 1'b1;
        @(negedge core_clk);
        panel_local_key = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    // ==================================================================
    // Main sequence
    initial begin
        {rst_n, nv_valid, factory_config, service_req, panel_key} = '0;
        {panel_entry_busy, panel_local_key, tx_valid, tx_last} = '0;
        {tx_data, status_byte, nv_ese, nv_sre, nv_addr} = '0;
        {error_cnt, samples_checked, clr_cnt, pon_cnt, abort_cnt} = '0;
        power_up_status_clear_choice = 1'b1;
        ren_n = 1'b1;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        check(bus_addr, 5'h12);
        addr = 5'(unsigned'($random(seed)) % 31);
        other = (addr == 5'h1e) ? 5'h00 : addr + 5'h01;
        nv_addr = addr;
        nv_ese = $random(seed);
        nv_sre = $random(seed);
        nv_valid = 1'b1;
        repeat (4) @(negedge core_clk);
        check(bus_addr, addr);
        check({ese_ff, sre_ff}, {nv_ese, nv_sre});
        check(pon_cnt, 1);
        // Local first: panel works, bus message then takes over
        ren_n = 1'b0;
        panel_key = 1'b1;
        panel_entry_busy = 1'b1;
        repeat (2) @(negedge core_clk);
        check(panel_key_ok, 1);
        cmd({3'h1, addr});
        panel_entry_busy = 1'b0;
        check(remote_ff, 1);
        check(abort_cnt > 0, 1);
        check(panel_key_ok, 0);
        check(listener_ff, 1);
        send_data(5, 1'b1);
        press_local();
        check(remote_ff, 0);
        check(panel_key_ok, 1);
        cmd({1'b0, ieee488_pkg::CMD_LLO});
        check({remote_ff, lockout_ff}, 2'h3);
        press_local();
        check(remote_ff, 1);
        // Another address must not take data
        cmd(8'h3f);
        cmd({3'h1, other});
        send_data(2, 1'b0);
        cmd({3'h1, addr});
        cmd({1'b0, ieee488_pkg::CMD_SDC});
        check(clr_cnt, 1);
        cmd({1'b0, ieee488_pkg::CMD_DCL});
        check(clr_cnt, 2);
        cmd({1'b0, ieee488_pkg::CMD_GET});
        check({clr_cnt[3:0], listener_ff}, {4'h2, 1'b1});
        // Fill the output queue until it refuses
        for (i = 0; i <= DEPTH; i++) begin
            @(negedge core_clk);
            check(tx_ready, i < DEPTH);
            tx_valid = (i < DEPTH);
            tx_data = $random(seed);
            tx_last = (i == DEPTH - 1);
            if (i < DEPTH) tx_exp.push_back({tx_last, tx_data});
        end
        cmd({3'h2, addr});
        check({talker_ff, listener_ff}, 2'h2);
        while (tx_exp.size() > 0) begin
            ctrl.get_byte($random(seed) & 3, got, ok);
            check({ok, got}, {1'b1, tx_exp.pop_front()});
        end
        // Serial poll returns status with the request flag
        status_byte = $random(seed);
        service_req = 1'b1;
        repeat (3) @(negedge core_clk);
        check(srq_n_oe, 1);
        cmd({1'b0, ieee488_pkg::CMD_SPE});
        cmd({3'h2, addr});
        ctrl.get_byte(1, got, ok);
        check(got[7:0], status_byte | 8'h40);
        service_req = 1'b0;
        cmd({1'b0, ieee488_pkg::CMD_SPD});
        check(srq_n_oe, 0);
        cmd({3'h1, addr});
        check({talker_ff, listener_ff}, 2'h1);
        // Parallel poll request gets no answer
        @(negedge core_clk);
        ctrl.c_eoi_n = 1'b0;
        repeat (4) begin
            @(negedge core_clk);
            check(dio_n_oe, 0);
        end
        ctrl.c_eoi_n = 1'b1;
        // Second reset under factory configuration
        rst_n = 1'b0;
        factory_config = 1'b1;
        power_up_status_clear_choice = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check(bus_addr, 5'h12);
        check(pon_cnt, 1);
        complete_run();
    end
endmodule
